// File: dcf_regs.svh
// dcf register offsets, field positions, reset values and timing counts
`ifndef DCF_REGS_SVH
`define DCF_REGS_SVH

// storage: 16 address bits give 65536 words, 17 give 131072
`define DCF_AW 16
`define DCF_DEPTH 65536
`define DCF_HALF 32768
`define DCF_WW 9
// default offsets chosen at master reset
`define DCF_OFF_PAR 127
`define DCF_OFF_SER 1023
// read-clock transitions before a first word falls through
`define DCF_FT_EDGES 3
// register byte addresses
`define DCF_A_CTRL 8'h00
`define DCF_A_STAT 8'h04
`define DCF_A_LEVEL 8'h08
`define DCF_A_OFFS 8'h0c
// control and status fields
`define DCF_CTRL_PRS 0
`define DCF_ST_FALL_THROUGH_MODE 0
`define DCF_ST_SER 1
`define DCF_ST_OVALID 2
`define DCF_ST_FLAGS 3

`endif

// File: dcf_pkg.sv
// dcf types shared by the fifo core and its register slave
`include "dcf_regs.svh"
package dcf_pkg;
	typedef logic [`DCF_WW-1:0] dcf_word_t;
	typedef logic [`DCF_AW-1:0] dcf_ptr_t;
	typedef logic [`DCF_AW:0]   dcf_cnt_t;
	typedef logic [31:0]        dcf_data_t;

	// whole state of the fifo core apart from the storage array
	typedef struct packed {
		dcf_ptr_t  wptr;
		dcf_ptr_t  rptr;
		dcf_cnt_t  cnt;
		logic      fall_through_mode;
		logic      ser_ld;
		dcf_ptr_t  eoff;
		dcf_ptr_t  foff;
		logic [1:0] wseq;
		logic [1:0] rseq;
		logic [4:0] sidx;
		logic      ovalid;
		logic [1:0] ft_cnt;
		dcf_word_t dout;
		logic      oe;
		logic      ef_n;
		logic      ff_n;
		logic      hf_n;
		logic      ae_n;
		logic      af_n;
	} dcf_state_s;
endpackage : dcf_pkg

// File: dcf_sync.sv
// dcf three-stage pin synchroniser with filtered value and edge pulses
module dcf_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_n,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q,
	output logic      [W-1:0] o_rise,
	output logic      [W-1:0] o_chg
);
	typedef struct packed {
		logic [W-1:0] s1, s2, s3, q, rise, chg;
	} dcf_sync_s;
	dcf_sync_s st_r, st_nxt;

	// value moves only once stages two and three agree
	always_comb
	begin
		st_nxt      = st_r;
		st_nxt.s1   = i_d;
		st_nxt.s2   = st_r.s1;
		st_nxt.s3   = st_r.s2;
		st_nxt.q    = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 | st_r.s3));
		st_nxt.rise = st_nxt.q & ~st_r.q;
		st_nxt.chg  = st_nxt.q ^ st_r.q;
	end

	// state register
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign o_q    = st_r.q;
	assign o_rise = st_r.rise;
	assign o_chg  = st_r.chg;
endmodule // dcf_sync

// File: dcf_apb.sv
// dcf apb slave: control pulse and status readback
`include "dcf_regs.svh"
module dcf_apb (
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_psel,
	input  wire logic              i_penable,
	input  wire logic              i_pwrite,
	input  wire logic [7:0]        i_paddr,
	input  wire dcf_pkg::dcf_data_t i_pwdata,
	input  wire logic [7:0]        i_status,
	input  wire dcf_pkg::dcf_cnt_t i_level,
	input  wire dcf_pkg::dcf_data_t i_offs,
	output dcf_pkg::dcf_data_t     o_prdata,
	output logic                   o_pready,
	output logic                   o_pslverr,
	output logic                   o_soft_prs
);
	import dcf_pkg::*;
	typedef struct packed {
		dcf_data_t prdata;
		logic      pready;
		logic      pslverr;
		logic      partial_reset_n;
	} dcf_apb_s;
	dcf_apb_s st_r, st_nxt;
	logic mapped;

	assign mapped = (i_paddr == `DCF_A_CTRL) || (i_paddr == `DCF_A_STAT)
		|| (i_paddr == `DCF_A_LEVEL) || (i_paddr == `DCF_A_OFFS);

	// setup cycle prepares the answer, access cycle completes it
	always_comb
	begin
		st_nxt        = st_r;
		st_nxt.partial_reset_n    = 1'b0;
		st_nxt.pready = 1'b0;
		if (i_psel && !i_penable)
		begin
			st_nxt.pready  = 1'b1;
			st_nxt.pslverr = !mapped;
			st_nxt.prdata  = '0;
			if (!i_pwrite)
			begin
				case (i_paddr)
					`DCF_A_STAT:  st_nxt.prdata = {24'h0, i_status};
					`DCF_A_LEVEL: st_nxt.prdata = 32'(i_level);
					`DCF_A_OFFS:  st_nxt.prdata = i_offs;
					default:      st_nxt.prdata = '0;
				endcase
			end
		end
		else if (i_psel && i_penable && st_r.pready)
		begin
			st_nxt.pslverr = 1'b0;
			st_nxt.prdata  = '0;
			if (i_pwrite && i_paddr == `DCF_A_CTRL)
				st_nxt.partial_reset_n = i_pwdata[`DCF_CTRL_PRS];
		end
	end

	// state register
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign o_prdata   = st_r.prdata;
	assign o_pready   = st_r.pready;
	assign o_pslverr  = st_r.pslverr;
	assign o_soft_prs = st_r.partial_reset_n;
endmodule // dcf_apb

// File: dcf_fifo_top.sv
// dcf deep fifo core: pin-sampled write and read ports, flags, offsets
//
// Contract
// - write enable low at write edge stores word
// - read enable low at read edge reads
// - output enable gates the data output drive
// - both port clocks fully independent, any rate; here both are sampled on i_clk and must run well below it
// - depth 65536 or 131072, nine-bit words; built here with 65536 only
// - standard mode: no output before a read
// - standard read moves next word to output
// - fall-through: first word after three transitions
// - fall-through: later words need read enable
// - mode pin sampled at master reset
// - status pins: empty/full or valid/space
// - half, almost flags in both modes
// - load pin picks 127 parallel or 1023 serial
// - serial enable with load shifts one bit
// - write enable with load loads offset word
// - read enable with load reads offsets
// - master reset zeroes both pointers
// - flags show empty after either reset
// - partial reset zeroes both pointers
// - partial reset keeps mode and offsets
// - retransmit rewinds only the read pointer
// - fall-through outputs chain to next inputs; no such chaining is built here
// - almost-full low above capacity minus offset
// - almost-empty low below empty offset
// - master reset zeroes output register
//
// Chosen here: the register addresses and register access over APB.
`include "dcf_regs.svh"
module dcf_fifo_top (
	input  wire logic               i_clk,
	input  wire logic               i_rst_n,
	input  wire logic               i_psel,
	input  wire logic               i_penable,
	input  wire logic               i_pwrite,
	input  wire logic [7:0]         i_paddr,
	input  wire dcf_pkg::dcf_data_t i_pwdata,
	output dcf_pkg::dcf_data_t      o_prdata,
	output logic                    o_pready,
	output logic                    o_pslverr,
	input  wire logic               i_wclk,
	input  wire logic               i_rclk,
	input  wire logic               i_wen_n,
	input  wire logic               i_ren_n,
	input  wire logic               i_oe_n,
	input  wire logic               i_mode_select_serial_in,
	input  wire logic               i_offset_load_select_n,
	input  wire logic               i_serial_load_enable_n,
	input  wire logic               i_master_reset_n,
	input  wire logic               i_partial_reset_n,
	input  wire logic               i_retransmit_n,
	input  wire dcf_pkg::dcf_word_t i_data_in_bus,
	output dcf_pkg::dcf_word_t      o_data_out_bus,
	output logic                    o_data_out_oe,
	output logic                    o_empty_flag_n,
	output logic                    o_full_flag_n,
	output logic                    o_half_full_flag_n,
	output logic                    o_almost_empty_flag_n,
	output logic                    o_almost_full_flag_n
);
	import dcf_pkg::*;

	localparam dcf_cnt_t FULL_CNT = dcf_cnt_t'(`DCF_DEPTH);
	localparam dcf_cnt_t HALF_CNT = dcf_cnt_t'(`DCF_HALF);
	localparam dcf_ptr_t OFF_PAR  = dcf_ptr_t'(`DCF_OFF_PAR);
	localparam dcf_ptr_t OFF_SER  = dcf_ptr_t'(`DCF_OFF_SER);
	localparam logic [1:0] FT_LAST = 2'(`DCF_FT_EDGES - 1);

	dcf_state_s st_r, st_nxt;
	dcf_word_t  mem_r [0:`DCF_DEPTH-1];
	dcf_word_t  rdata, din;
	dcf_cnt_t   lvl_r;
	logic [1:0] clk_rise, clk_chg;
	logic [17:0] pin_q;
	logic wen_q, ren_q, oe_n_q, si_q, ld_n_q, sen_q, mrs_q, prs_q, rt_q;
	logic soft_prs, master_reset_n, any_rst, full, empty;
	logic wr_evt, rd_evt, rd_tr;
	logic wr_fire, off_par_wr, off_ser_wr, rt_fire, off_rd, rd_req;
	logic rd_std, adv, drop, ft_step, fall, mem_rd;

	////////////////////////////////////////////////////////////////////////
	// pin sampling; port clocks are plain inputs, edges seen here
	dcf_sync #(.W(2)) u_clk_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_d     ({i_rclk, i_wclk}),
		.o_q     (),
		.o_rise  (clk_rise),
		.o_chg   (clk_chg)
	);
	// active-low pins enter inverted so cleared stages read as idle
	dcf_sync #(.W(18)) u_pin_sync (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.i_d     ({i_data_in_bus, ~i_wen_n, ~i_ren_n, ~i_oe_n,
			i_mode_select_serial_in, ~i_offset_load_select_n,
			~i_serial_load_enable_n, ~i_master_reset_n,
			~i_partial_reset_n, ~i_retransmit_n}),
		.o_q     (pin_q),
		.o_rise  (),
		.o_chg   ()
	);

	// register slave
	dcf_apb u_apb (
		.i_clk      (i_clk),
		.i_rst_n    (i_rst_n),
		.i_psel     (i_psel),
		.i_penable  (i_penable),
		.i_pwrite   (i_pwrite),
		.i_paddr    (i_paddr),
		.i_pwdata   (i_pwdata),
		.i_status   ({st_r.af_n, st_r.ae_n, st_r.hf_n, st_r.ff_n,
			st_r.ef_n, st_r.ovalid, st_r.ser_ld, st_r.fall_through_mode}),
		.i_level    (lvl_r),
		.i_offs     ({st_r.foff, st_r.eoff}),
		.o_prdata   (o_prdata),
		.o_pready   (o_pready),
		.o_pslverr  (o_pslverr),
		.o_soft_prs (soft_prs)
	);

	////////////////////////////////////////////////////////////////////////
	// decoded pins and events
	assign din    = pin_q[17:9];
	assign wen_q  = pin_q[8];
	assign ren_q  = pin_q[7];
	assign oe_n_q = !pin_q[6];
	assign si_q   = pin_q[5];
	assign ld_n_q = !pin_q[4];
	assign sen_q  = pin_q[3];
	assign mrs_q  = pin_q[2];
	assign prs_q  = pin_q[1];
	assign rt_q   = pin_q[0];
	assign wr_evt = clk_rise[0];
	assign rd_evt = clk_rise[1];
	assign rd_tr  = clk_chg[1];
	assign master_reset_n     = mrs_q;
	assign any_rst = mrs_q | prs_q | soft_prs;
	assign full    = (st_r.cnt == FULL_CNT);
	assign empty   = (st_r.cnt == '0);
	assign lvl_r   = st_r.cnt + dcf_cnt_t'(st_r.fall_through_mode & st_r.ovalid);
	assign rdata   = mem_r[st_r.rptr];

	// port operations; resets block all of them
	assign wr_fire = wr_evt & wen_q & ld_n_q & !full & !any_rst;
	assign off_par_wr = wr_evt & wen_q & !ld_n_q & !any_rst;
	assign off_ser_wr = wr_evt & sen_q & !ld_n_q & !any_rst;
	assign rt_fire = rd_evt & rt_q & !any_rst;
	assign off_rd  = rd_evt & ren_q & !ld_n_q & !any_rst & !rt_fire;
	assign rd_req  = rd_evt & ren_q & ld_n_q & !any_rst & !rt_fire;
	assign rd_std  = rd_req & !st_r.fall_through_mode & !empty;
	assign adv     = rd_req & st_r.fall_through_mode & st_r.ovalid & !empty;
	assign drop    = rd_req & st_r.fall_through_mode & st_r.ovalid & empty;
	assign ft_step = st_r.fall_through_mode & !st_r.ovalid & !empty & rd_tr
		& !any_rst & !rt_fire;
	assign fall    = ft_step & (st_r.ft_cnt == FT_LAST);
	assign mem_rd  = rd_std | adv | fall;

	////////////////////////////////////////////////////////////////////////
	// storage array, written on accepted words only
	always_ff @(posedge i_clk)
	begin
		if (wr_fire)
			mem_r[st_r.wptr] <= din;
	end

	// next state of the core
	always_comb
	begin
		dcf_cnt_t lv;
		lv = '0;
		st_nxt = st_r;
		st_nxt.oe = !oe_n_q;
		if (master_reset_n)
		begin
			st_nxt.fall_through_mode   = si_q;
			st_nxt.ser_ld = ld_n_q;
			st_nxt.eoff   = ld_n_q ? OFF_SER : OFF_PAR;
			st_nxt.foff   = ld_n_q ? OFF_SER : OFF_PAR;
		end
		if (any_rst)
		begin
			// mode and offsets survive a partial reset
			st_nxt.wptr   = '0;
			st_nxt.rptr   = '0;
			st_nxt.cnt    = '0;
			st_nxt.ovalid = 1'b0;
			st_nxt.ft_cnt = '0;
			st_nxt.dout   = '0;
			st_nxt.wseq   = '0;
			st_nxt.rseq   = '0;
			st_nxt.sidx   = '0;
		end
		else
		begin
			if (wr_fire)
				st_nxt.wptr = st_r.wptr + 1'b1;
			// parallel offsets: empty low, empty high, full low, full high
			if (off_par_wr)
			begin
				case (st_r.wseq)
					2'h0:    st_nxt.eoff[8:0]  = din;
					2'h1:    st_nxt.eoff[15:9] = din[6:0];
					2'h2:    st_nxt.foff[8:0]  = din;
					default: st_nxt.foff[15:9] = din[6:0];
				endcase
				st_nxt.wseq = st_r.wseq + 1'b1;
			end
			// serial offsets: empty then full, low bit first
			if (off_ser_wr)
			begin
				if (st_r.sidx[4])
					st_nxt.foff[st_r.sidx[3:0]] = si_q;
				else
					st_nxt.eoff[st_r.sidx[3:0]] = si_q;
				st_nxt.sidx = st_r.sidx + 1'b1;
			end
			if (mem_rd)
			begin
				st_nxt.rptr = st_r.rptr + 1'b1;
				st_nxt.dout = rdata;
			end
			if (fall || adv)
				st_nxt.ovalid = 1'b1;
			if (drop)
				st_nxt.ovalid = 1'b0;
			// count read-clock transitions while a word waits to fall
			if (ft_step)
				st_nxt.ft_cnt = fall ? 2'h0 : st_r.ft_cnt + 1'b1;
			else if (st_r.ovalid || empty)
				st_nxt.ft_cnt = '0;
			if (off_rd)
			begin
				case (st_r.rseq)
					2'h0:    st_nxt.dout = st_r.eoff[8:0];
					2'h1:    st_nxt.dout = {2'h0, st_r.eoff[15:9]};
					2'h2:    st_nxt.dout = st_r.foff[8:0];
					default: st_nxt.dout = {2'h0, st_r.foff[15:9]};
				endcase
				st_nxt.rseq = st_r.rseq + 1'b1;
			end
			st_nxt.cnt = st_r.cnt + dcf_cnt_t'(wr_fire)
				- dcf_cnt_t'(mem_rd);
			if (rt_fire)
			begin
				// data from location zero to the write pointer is readable
				st_nxt.rptr   = '0;
				st_nxt.ovalid = 1'b0;
				st_nxt.ft_cnt = '0;
				st_nxt.cnt    = {1'b0, st_nxt.wptr};
			end
		end
		// flags from the next state, so resets show an empty queue
		lv = st_nxt.cnt + dcf_cnt_t'(st_nxt.fall_through_mode & st_nxt.ovalid);
		st_nxt.ef_n = st_nxt.fall_through_mode ? !st_nxt.ovalid
			: (st_nxt.cnt != '0);
		st_nxt.ff_n = (st_nxt.cnt != FULL_CNT);
		st_nxt.hf_n = !(lv > HALF_CNT);
		st_nxt.af_n = !(lv > (FULL_CNT - {1'b0, st_nxt.foff}));
		st_nxt.ae_n = !(lv < {1'b0, st_nxt.eoff});
	end

	// state register; idle defaults to standard mode, parallel, 127
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_r      <= '0;
			st_r.eoff <= OFF_PAR;
			st_r.foff <= OFF_PAR;
			st_r.ff_n <= 1'b1;
			st_r.hf_n <= 1'b1;
			st_r.af_n <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	// outputs straight from the state register
	assign o_data_out_bus        = st_r.dout;
	assign o_data_out_oe         = st_r.oe;
	assign o_empty_flag_n        = st_r.ef_n;
	assign o_full_flag_n         = st_r.ff_n;
	assign o_half_full_flag_n    = st_r.hf_n;
	assign o_almost_empty_flag_n = st_r.ae_n;
	assign o_almost_full_flag_n  = st_r.af_n;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_ft_last_edge;
		st_r.fall_through_mode && !st_r.ovalid && !empty && rd_tr
			&& st_r.ft_cnt == 2'h2 && !any_rst && !rt_fire;
	endsequence
	sequence s_ft_early;
		st_r.fall_through_mode && !st_r.ovalid && st_r.ft_cnt != 2'h2 && !any_rst;
	endsequence

	a_write_store: assert property (
		wr_fire && !mem_rd && !rt_fire |=> st_r.cnt == $past(st_r.cnt) + 1'b1)
		else $error("accepted write did not raise the count");
	a_full_ignore: assert property (
		full && wr_evt && wen_q && !any_rst |=> $stable(st_r.wptr))
		else $error("write pointer moved while full");
	a_std_read: assert property (
		rd_std |=> st_r.dout == $past(rdata)
			&& st_r.rptr == $past(st_r.rptr) + 1'b1)
		else $error("standard read did not present the stored word");
	a_empty_read: assert property (
		empty && rd_req && !st_r.fall_through_mode |=> $stable(st_r.rptr))
		else $error("read pointer moved while empty");
	a_reset_flags: assert property (
		any_rst |=> o_empty_flag_n == st_r.fall_through_mode && o_full_flag_n
			&& o_half_full_flag_n)
		else $error("flags did not show an empty queue after reset");
	a_std_hold: assert property (
		!st_r.fall_through_mode && !mem_rd && !off_rd && !any_rst |=> $stable(st_r.dout))
		else $error("output changed without a read in standard mode");
	a_fall_three: assert property (
		s_ft_last_edge |=> st_r.ovalid)
		else $error("first word did not fall through on third transition");
	a_fall_early: assert property (
		s_ft_early |=> !st_r.ovalid || $past(adv))
		else $error("first word fell through too early");
	a_master_clear: assert property (
		master_reset_n |=> st_r.wptr == '0 && st_r.rptr == '0 && st_r.dout == '0)
		else $error("master reset left pointers or output set");
	a_partial_keep: assert property (
		prs_q && !master_reset_n |=> $stable(st_r.fall_through_mode) && $stable(st_r.eoff)
			&& $stable(st_r.foff) && st_r.rptr == '0)
		else $error("partial reset disturbed mode or offsets");
	a_rt_rewind: assert property (
		rt_fire && !wr_fire |=> st_r.rptr == '0 && $stable(st_r.wptr))
		else $error("retransmit did not rewind the read pointer only");
	a_half_flag: assert property (
		o_half_full_flag_n == !(lvl_r > HALF_CNT))
		else $error("half-full flag disagrees with the level");
	a_oe_drive: assert property (
		oe_n_q |=> !o_data_out_oe)
		else $error("output driven while output enable is high");
endmodule // dcf_fifo_top

// File: dcf_port_model.sv
// dcf partner model: producer and consumer logic on the fifo pins
module dcf_port_model (
	input  wire logic          i_clk,
	output logic               o_wclk,
	output logic               o_rclk,
	output logic               o_wen_n,
	output logic               o_ren_n,
	output logic               o_oe_n,
	output logic               o_si,
	output logic               o_ld_n,
	output logic               o_sen_n,
	output logic               o_mrs_n,
	output logic               o_prs_n,
	output logic               o_rt_n,
	output dcf_pkg::dcf_word_t o_din
);
	timeunit 1ns;
	timeprecision 1ns;
	import dcf_pkg::*;

	// idle pin levels from time zero
	initial
	begin
		{o_wclk, o_rclk, o_si} = 3'b000;
		{o_wen_n, o_ren_n, o_oe_n, o_ld_n} = 4'hf;
		{o_sen_n, o_mrs_n, o_prs_n, o_rt_n} = 4'hf;
		o_din = 9'h000;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// one write clock with qualifiers held well around its rise
	task automatic wport(input logic wen, ld, serial_load_enable_n, si, input dcf_word_t d);
		hold(1);
		o_wen_n <= wen;
		o_ld_n <= ld;
		o_sen_n <= serial_load_enable_n;
		o_si <= si;
		o_din <= d;
		hold(6);
		o_wclk <= 1'b1;
		hold(6);
		o_wclk <= 1'b0;
		hold(6);
		o_wen_n <= 1'b1;
		o_ld_n <= 1'b1;
		o_sen_n <= 1'b1;
		o_din <= ~d; // released bus shows no stale word
	endtask

	// one read clock; the consumer alone advances the output
	task automatic rport(input logic ren, ld, rt);
		hold(1);
		o_ren_n <= ren;
		o_ld_n <= ld;
		o_rt_n <= rt;
		hold(6);
		o_rclk <= 1'b1;
		hold(6);
		o_rclk <= 1'b0;
		hold(6);
		o_ren_n <= 1'b1;
		o_ld_n <= 1'b1;
		o_rt_n <= 1'b1;
	endtask

	// bare read clock transitions with read enable idle
	task automatic rtog(input int n);
		repeat (n)
		begin
			hold(6);
			o_rclk <= ~o_rclk;
		end
		hold(6);
	endtask

	// master reset with mode and load levels held across release
	task automatic mreset(input logic ft, ld);
		hold(1);
		o_mrs_n <= 1'b0;
		o_si <= ft;
		o_ld_n <= ld;
		hold(8);
		o_mrs_n <= 1'b1;
		hold(6);
		o_ld_n <= 1'b1;
		o_si <= 1'b0;
		hold(6);
	endtask

	task automatic partial_reset_n();
		hold(1);
		o_prs_n <= 1'b0;
		hold(8);
		o_prs_n <= 1'b1;
		hold(8);
	endtask

	task automatic oe(input logic v);
		hold(1);
		o_oe_n <= v;
		hold(8);
	endtask
endmodule // dcf_port_model

// File: testbench.sv
// dcf testbench: apb master, fifo scenarios and verdict
`include "dcf_regs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import dcf_pkg::*;

	logic      i_clk = 1'b0;
	logic      i_rst_n = 1'b0;
	logic      psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	dcf_data_t pwdata = 32'h0, prdata;
	logic      pready, pslverr, wclk, rclk, wen_n, ren_n, oe_n, si, ld_n;
	logic      sen_n, mrs_n, prs_n, rt_n, out_oe, ef_n, ff_n, hf_n, ae_n, af_n;
	dcf_word_t din, dout;
	int        err_total = 0, num_checks = 0;

	always #25 i_clk = ~i_clk;

	dcf_fifo_top dcf_fifo_top_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_wclk(wclk), .i_rclk(rclk),
		.i_wen_n(wen_n), .i_ren_n(ren_n), .i_oe_n(oe_n),
		.i_mode_select_serial_in(si), .i_offset_load_select_n(ld_n),
		.i_serial_load_enable_n(sen_n), .i_master_reset_n(mrs_n),
		.i_partial_reset_n(prs_n), .i_retransmit_n(rt_n),
		.i_data_in_bus(din), .o_data_out_bus(dout), .o_data_out_oe(out_oe),
		.o_empty_flag_n(ef_n), .o_full_flag_n(ff_n),
		.o_half_full_flag_n(hf_n), .o_almost_empty_flag_n(ae_n),
		.o_almost_full_flag_n(af_n));

	dcf_port_model dcf_port_model_inst (.i_clk(i_clk), .o_wclk(wclk),
		.o_rclk(rclk), .o_wen_n(wen_n), .o_ren_n(ren_n), .o_oe_n(oe_n),
		.o_si(si), .o_ld_n(ld_n), .o_sen_n(sen_n), .o_mrs_n(mrs_n),
		.o_prs_n(prs_n), .o_rt_n(rt_n), .o_din(din));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// apb transfer held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a,
		input dcf_data_t wd, output dcf_data_t rd, output logic err);
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge i_clk);
		penable <= 1'b1;
		// ends once pready is seen high; no timeout of its own, so only the watchdog ends a hung wait
		do
		begin
			@(posedge i_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input dcf_word_t d);
		dcf_port_model_inst.wport(1'b0, 1'b1, 1'b1, 1'b0, d);
	endtask

	task automatic rdq();
		dcf_port_model_inst.rport(1'b0, 1'b1, 1'b1);
	endtask

	// offset readback: empty low, empty high, full low, full high
	task automatic chk_offs(input int e, f);
		int v[4];
		v = '{e & 32'h1ff, e >> 9, f & 32'h1ff, f >> 9};
		for (int i = 0; i < 4; i++)
		begin
			dcf_port_model_inst.rport(1'b0, 1'b0, 1'b1);
			chk(dout, v[i]);
		end
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		dcf_data_t rd;
		logic      e;
		apb(1'b0, a, 32'h0, rd, e);
		chk(rd, exp);
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk({ef_n, ff_n, hf_n, ae_n, af_n}, 5'b01101);
		chk(dout, 9'h000);
		$display("test reset done at %0t", $time);
	endtask

	task automatic t_std();
		for (int i = 0; i < 3; i++)
			wr(dcf_word_t'(9'h1a0 + i));
		chk(dout, 9'h000);
		chk(ef_n, 1'b1);
		reg_rd(`DCF_A_LEVEL, 32'd3);
		rdq();
		chk(dout, 9'h1a0);
		rdq();
		rdq();
		rdq();
		chk(dout, 9'h1a2);
		chk(ef_n, 1'b0);
		dcf_port_model_inst.rport(1'b1, 1'b1, 1'b0);
		rdq();
		chk(dout, 9'h1a0);
		$display("test standard done at %0t", $time);
	endtask

	task automatic t_offs();
		dcf_data_t rd;
		logic      e;
		dcf_port_model_inst.partial_reset_n();
		chk(ef_n, 1'b0);
		reg_rd(`DCF_A_LEVEL, 32'd0);
		for (int i = 0; i < 4; i++)
			dcf_port_model_inst.wport(1'b0, 1'b0, 1'b1, 1'b0,
				(i == 0) ? 9'h005 : (i == 2) ? 9'h003 : 9'h000);
		chk_offs(5, 3);
		for (int i = 0; i < 4; i++)
			wr(dcf_word_t'(9'h050 + i));
		chk(ae_n, 1'b0);
		wr(9'h054);
		chk(ae_n, 1'b1);
		apb(1'b1, `DCF_A_CTRL, 32'h1, rd, e);
		reg_rd(`DCF_A_LEVEL, 32'd0);
		chk_offs(5, 3);
		reg_rd(`DCF_A_STAT, 32'h000000b0);
		apb(1'b0, 8'h40, 32'h0, rd, e);
		chk(e, 1'b1);
		chk(rd, 32'h0);
		$display("test offsets done at %0t", $time);
	endtask

	task automatic t_ft();
		logic [31:0] sv;
		sv = {16'd7, 16'd3};
		dcf_port_model_inst.mreset(1'b1, 1'b1);
		chk({dout, ef_n}, {9'h000, 1'b1});
		reg_rd(`DCF_A_STAT, 32'h000000bb);
		chk_offs(1023, 1023);
		for (int i = 0; i < 32; i++)
			dcf_port_model_inst.wport(1'b1, 1'b0, 1'b0, sv[i], 9'h000);
		chk_offs(3, 7);
		wr(9'h0c3);
		dcf_port_model_inst.rtog(4);
		chk({dout, ef_n, ae_n}, {9'h0c3, 2'b00});
		wr(9'h0c4);
		dcf_port_model_inst.rtog(4);
		chk(dout, 9'h0c3);
		rdq();
		chk(dout, 9'h0c4);
		$display("test fall through done at %0t", $time);
	endtask

	task automatic t_oe();
		dcf_port_model_inst.oe(1'b0);
		chk(out_oe, 1'b1);
		dcf_port_model_inst.oe(1'b1);
		chk(out_oe, 1'b0);
		$display("test output enable done at %0t", $time);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		repeat (16) @(posedge i_clk);
		i_rst_n <= 1'b1;
		@(posedge i_clk);
		t_reset();
		t_std();
		t_offs();
		t_ft();
		t_oe();
		report_and_stop();
	end

	// watchdog well past the expected run time
	initial
	begin
		#2000000;
		err_total++;
		report_and_stop();
	end
endmodule // testbench
